/* File: core/usb_power_and_irq_status.sv */
// USB power control, sleep guard and top-level interrupt flag registers.
// Assumes packet-engine events arrive on clk; data pins are asynchronous.
// Functional notes
// RL1 - Pending bit flags activity not yet interrupted
// RL2 - Guard set blocks Sleep on activity
// RL3 - Busy while active or still shutting down
// RL4 - Software avoids registers while busy and off
// RL5 - Suspend gates USB clock, transceiver low-power
// RL6 - Disabled: outputs inactive, pins, analog released; here sleep_block and token_fifo_advance are not gated by enable
// RL7 - Stall flag on received or sent STALL
// RL8 - Attach flag: host, quiet, not SE0
// RL9 - Resume flag after K held 2.5us
// RL10 - Software disables resume interrupt outside Suspend
// RL11 - Idle flag after 3 ms idle
// RL12 - Token flag when token processing ends
// RL13 - Clearing token flag advances status FIFO
// RL14 - Frame-start flag on SOF or threshold
// RL15 - Error summary only from enabled errors
// RL16 - Flags set by hardware, write-one clears
// RL17 - Unimplemented bits read zero, ignore writes
// RL18 - Bit zero: reset device, detach host
// RL19 - Set beats simultaneous clear
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module usb_power_and_irq_status
  import usb_pwr_pkg::*;
#(
  parameter int IDLE_CYCLES     = IDLE_CYCLES_DOC,
  parameter int CNT_W           = 18,
  parameter int SHUTDOWN_CYCLES = SHUTDOWN_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Register port
  input  wire reg_req_t    req,
  output logic [31:0]      rdata,
  // Data line pins, asynchronous
  input  wire logic        dp_pin,
  input  wire logic        dm_pin,
  // Packet engine and sibling registers
  input  wire pkt_events_t pkt_ev,
  input  wire logic        host_role_enable,
  input  wire logic [7:0]  err_flags,
  input  wire logic [7:0]  err_enable,
  // Power and analog controls
  output logic             usb_clk_enable,
  output logic             xcvr_low_power,
  output logic             pins_owned,
  output logic             analog_enable,
  output logic             sleep_block,
  output logic             token_fifo_advance,
  // Interrupt
  output logic             irq
);

  // Reject settings the counters cannot hold
  initial begin
    if (IDLE_CYCLES < 2 || IDLE_CYCLES >= (1 << CNT_W) - 1 || SHUTDOWN_CYCLES < 1 ||
        SHUTDOWN_CYCLES > 255 || K_HOLD_CYCLES >= IDLE_CYCLES)
      $error("usb_power_and_irq_status: unsupported parameter values");
  end

  // Compare points; the hold counter starts at zero, so each is its time less one
  localparam logic [CNT_W-1:0] K_CNT     = CNT_W'(K_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] QUIET_CNT = CNT_W'(QUIET_CYCLES - 1);
  localparam logic [CNT_W-1:0] IDLE_CNT  = CNT_W'(IDLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_MAX   = {CNT_W{1'b1}};
  localparam logic [7:0]       SHUT_LOAD = 8'(SHUTDOWN_CYCLES);

  logic              enable_q;      // Module operation enable
  logic              suspend_q;     // Suspend request
  logic              guard_q;       // Sleep entry guard
  logic [7:0]        shut_cnt_q;    // Shutdown time left after disable
  logic              busy;          // Module busy view
  logic              pending_q;     // Activity pending
  logic [FLAG_W-1:0] flags_q;       // Sticky event flags
  logic [FLAG_W-1:0] irq_en_q;      // Interrupt enable mask
  logic [FLAG_W-1:0] ev_set;        // Hardware set requests
  logic [FLAG_W-1:0] sw_clr;        // Software clear requests
  logic [FLAG_W-1:0] flag_view;     // Flags as software reads them
  logic              err_summary;   // Unmasked error summary
  logic [1:0]        dp_sync_q;     // Pin synchronisers
  logic [1:0]        dm_sync_q;
  line_t             line_now;      // Decoded synchronised line state
  line_t             line_q;        // Line state one cycle ago
  logic [CNT_W-1:0]  hold_cnt_q;    // Cycles the line has stayed unchanged
  logic              line_same;
  logic              attach_armed_q;// SE0 seen since last attach
  logic              se0_armed_q;   // Not-SE0 seen since last reset/detach
  logic              activity;      // Line changed to a state other than J this cycle

  // Register write decode
  logic wr_pwr;
  logic wr_flags;
  logic wr_en;
  logic wr_clr;
  always_comb begin
    wr_pwr   = 1'b0;
    wr_flags = 1'b0;
    wr_en    = 1'b0;
    wr_clr   = 1'b0;
    if (req.wr && req.addr == OFS_POWER_CONTROL) begin
      wr_pwr = 1'b1;
    end else if (req.wr && req.addr == OFS_INTERRUPT_FLAGS) begin
      wr_flags = 1'b1;
    end else if (req.wr && req.addr == OFS_IRQ_ENABLE) begin
      wr_en = 1'b1;
    end else if (req.wr && req.addr == OFS_IRQ_CLEAR) begin
      wr_clr = 1'b1;
    end
  end

  // Power control bits; only bits 4, 1 and 0 hold writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enable_q  <= 1'b0;
      suspend_q <= 1'b0;
      guard_q   <= 1'b0;
    end else if (wr_pwr) begin
      enable_q  <= req.wdata[PB_ENABLE];   // see RL6
      suspend_q <= req.wdata[PB_SUSPEND];  // see RL5
      guard_q   <= req.wdata[PB_GUARD];    // see RL2
    end
  end

  // Shutdown timer: the analog part needs time to settle before re-enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shut_cnt_q <= 8'h00;
    end else if (enable_q) begin
      shut_cnt_q <= SHUT_LOAD;
    end else if (shut_cnt_q != 8'h00) begin
      shut_cnt_q <= shut_cnt_q - 8'h01;
    end
  end

  // Busy while on or still winding down
  assign busy = enable_q || (shut_cnt_q != 8'h00); // see RL3

  // Power outputs follow the control bits directly
  assign usb_clk_enable = enable_q && !suspend_q;  // see RL5
  assign xcvr_low_power = suspend_q || !enable_q;  // see RL5
  assign pins_owned     = enable_q;                // see RL6
  assign analog_enable  = enable_q;                // see RL6

  // Pin synchronisers; first stage read only by the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dp_sync_q <= 2'b00;
      dm_sync_q <= 2'b00;
    end else begin
      dp_sync_q <= {dp_sync_q[0], dp_pin};
      dm_sync_q <= {dm_sync_q[0], dm_pin};
    end
  end

  // Full-speed line decode: J is D+ high, K is D- high
  always_comb begin
    case ({dp_sync_q[1], dm_sync_q[1]})
      2'b00:   line_now = LS_SE0;
      2'b10:   line_now = LS_J;
      2'b01:   line_now = LS_K;
      default: line_now = LS_SE1;
    endcase
  end

  // Only a change to a state other than J counts as activity, since J is the idle level
  assign line_same = (line_now == line_q);
  assign activity  = !line_same && line_now != LS_J;

  // Hold counter: cycles the line state has stayed put, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_q     <= LS_SE0;
      hold_cnt_q <= '0;
    end else begin
      line_q <= line_now;
      if (!line_same) begin
        hold_cnt_q <= '0;
      end else if (hold_cnt_q != CNT_MAX) begin
        hold_cnt_q <= hold_cnt_q + 1'b1;
      end
    end
  end

  // Arming: attach needs an SE0 first, reset/detach needs a connection first
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      attach_armed_q <= 1'b0;
      se0_armed_q    <= 1'b0;
    end else begin
      if (line_now == LS_SE0) begin
        attach_armed_q <= 1'b1;
      end else if (ev_set[FB_ATTACH]) begin
        attach_armed_q <= 1'b0;
      end
      if (line_now != LS_SE0) begin
        se0_armed_q <= 1'b1;
      end else if (ev_set[FB_RESET_DETACH]) begin
        se0_armed_q <= 1'b0;
      end
    end
  end

  // Hardware event sources; the disabled module raises nothing
  always_comb begin
    ev_set = '0;
    if (enable_q) begin
      ev_set[FB_STALL] = host_role_enable ? pkt_ev.stall_rx : pkt_ev.stall_tx;        // see RL7
      ev_set[FB_ATTACH] = host_role_enable && attach_armed_q && line_same &&
                          line_now != LS_SE0 && hold_cnt_q == QUIET_CNT;             // see RL8
      ev_set[FB_RESUME] = line_same && line_now == LS_K && hold_cnt_q == K_CNT;      // see RL9
      ev_set[FB_IDLE] = line_same && line_now == LS_J && hold_cnt_q == IDLE_CNT;     // see RL11
      ev_set[FB_TOKEN_DONE] = pkt_ev.token_done;                                      // see RL12
      ev_set[FB_FRAME_START] = host_role_enable ? pkt_ev.sof_threshold : pkt_ev.sof_rx; // see RL14
      // Same SE0 timer serves reset in device role and detach in host role
      ev_set[FB_RESET_DETACH] = se0_armed_q && line_same && line_now == LS_SE0 &&
                                hold_cnt_q == QUIET_CNT;                              // see RL18
    end
  end

  // Software clear: write one to the flag register or the clear register
  always_comb begin
    sw_clr = '0;
    if (wr_flags || wr_clr) begin
      sw_clr = req.wdata[FLAG_W-1:0];
    end
    sw_clr[FB_ERROR] = 1'b0; // see RL17
  end

  // Sticky flags, set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_q <= FLAGS_RESET;
    end else begin
      flags_q <= (flags_q & ~sw_clr) | ev_set; // see RL16, see RL19
    end
  end

  // Token status FIFO steps on when a set token flag is cleared
  assign token_fifo_advance = sw_clr[FB_TOKEN_DONE] && flags_q[FB_TOKEN_DONE]; // see RL13

  // Error summary is a live view of unmasked errors, never sticky
  assign err_summary = |(err_flags & err_enable); // see RL15

  always_comb begin
    flag_view           = flags_q;
    flag_view[FB_ERROR] = err_summary;
  end

  // Interrupt enables
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_en_q <= FLAGS_RESET;
    end else if (wr_en) begin
      irq_en_q <= req.wdata[FLAG_W-1:0];
    end
  end

  // Held low while disabled so no stale flag disturbs the processor
  assign irq = enable_q && |(flag_view & irq_en_q); // see RL6

  // Activity pending: set by line activity, dropped once an interrupt is raised
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pending_q <= 1'b0;
    end else if (!enable_q || irq) begin
      pending_q <= 1'b0; // see RL1
    end else if (activity) begin
      pending_q <= 1'b1; // see RL1
    end
  end

  // Sleep guard; a limitation: activity this cycle counts only once synchronised
  assign sleep_block = guard_q && (pending_q || activity || irq); // see RL2

  // Read data, one cycle after the strobe; unmapped and unused bits read zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= RDATA_RESET;
    end else if (req.rd) begin
      rdata <= RDATA_RESET; // see RL17
      if (req.addr == OFS_POWER_CONTROL) begin
        rdata[PB_ENABLE]  <= enable_q;
        rdata[PB_SUSPEND] <= suspend_q;
        rdata[PB_BUSY]    <= busy;
        rdata[PB_GUARD]   <= guard_q;
        rdata[PB_PENDING] <= pending_q;
      end else if (req.addr == OFS_INTERRUPT_FLAGS) begin
        rdata[FLAG_W-1:0] <= flag_view;
      end else if (req.addr == OFS_IRQ_ENABLE) begin
        rdata[FLAG_W-1:0] <= irq_en_q;
      end
    end else begin
      rdata <= RDATA_RESET;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence k_held_s;
    line_now == LS_K && line_same;
  endsequence

  sequence j_held_s;
    line_now == LS_J && line_same;
  endsequence

  sequence se0_held_s;
    line_now == LS_SE0 && line_same;
  endsequence

  chk_busy_after_off: assert property ($fell(enable_q) |-> busy [*8]) // see RL3
    else $error("busy dropped too soon after disable");
  chk_busy_zero_ready: assert property (!busy |-> !enable_q && shut_cnt_q == 8'h00) // see RL3
    else $error("busy low while not ready");
  chk_suspend_gates_clock: assert property (suspend_q |-> !usb_clk_enable && xcvr_low_power) // see RL5
    else $error("suspend did not gate clock");
  chk_disabled_outputs_off: assert property (!enable_q |-> !pins_owned && !analog_enable && !irq) // see RL6
    else $error("outputs active while disabled");
  chk_guard_off_free: assert property (!guard_q |-> !sleep_block) // see RL2
    else $error("sleep blocked without guard");
  chk_set_beats_clear: assert property (ev_set[FB_TOKEN_DONE] && sw_clr[FB_TOKEN_DONE]
                                        |=> flags_q[FB_TOKEN_DONE]) // see RL19
    else $error("event lost to simultaneous clear");
  chk_flag_stays_set: assert property (flags_q[FB_STALL] && !sw_clr[FB_STALL] |=> flags_q[FB_STALL]) // see RL16
    else $error("flag dropped without clear");
  chk_resume_k_time: assert property (ev_set[FB_RESUME] |-> hold_cnt_q == K_CNT && $past(line_now) == LS_K) // see RL9
    else $error("resume raised without held K");
  chk_attach_host_only: assert property (ev_set[FB_ATTACH] |-> host_role_enable && line_now != LS_SE0) // see RL8
    else $error("attach outside host role or in SE0");
  chk_error_summary_live: assert property (req.rd && req.addr == OFS_INTERRUPT_FLAGS
                                           |=> rdata[FB_ERROR] == $past(err_summary)) // see RL15
    else $error("error summary mismatch");
  chk_token_advance_pulse: assert property (token_fifo_advance |-> ##1 !flags_q[FB_TOKEN_DONE] ||
                                            $past(ev_set[FB_TOKEN_DONE])) // see RL13
    else $error("token advance without clear");
  chk_upper_bits_zero: assert property ($past(req.rd) |-> rdata[31:8] == 24'h000000) // see RL17
    else $error("unimplemented bits not zero");
  chk_pending_drops: assert property ((irq and k_held_s) |=> !pending_q) // see RL1
    else $error("pending kept after interrupt");
  chk_pending_off_disabled: assert property (!enable_q |=> !pending_q) // see RL1
    else $error("pending kept while disabled");
  chk_sleep_on_pending: assert property (guard_q && pending_q |-> sleep_block) // see RL2
    else $error("sleep not blocked with activity pending");

  // Line events: a compare point that raised nothing would lose the event for good
  chk_resume_raises: assert property ((k_held_s and enable_q && hold_cnt_q == K_CNT) // see RL9
                                      |=> flags_q[FB_RESUME])
    else $error("resume not raised after held K");
  chk_idle_raises: assert property ((j_held_s and enable_q && hold_cnt_q == IDLE_CNT) // see RL11
                                    |=> flags_q[FB_IDLE])
    else $error("idle not raised after held J");
  chk_reset_raises: assert property ((se0_held_s and enable_q && se0_armed_q && // see RL18
                                      hold_cnt_q == QUIET_CNT) |=> flags_q[FB_RESET_DETACH])
    else $error("reset or detach not raised after held SE0");
  chk_attach_raises: assert property ((j_held_s and host_role_enable && attach_armed_q && // see RL8
                                       enable_q && hold_cnt_q == QUIET_CNT) |=> flags_q[FB_ATTACH])
    else $error("attach not raised after quiet line");

  // Engine events and the register side
  chk_token_raises: assert property (enable_q && pkt_ev.token_done |=> flags_q[FB_TOKEN_DONE]) // see RL12
    else $error("token flag not raised");
  chk_frame_device: assert property (enable_q && !host_role_enable && pkt_ev.sof_rx |=> flags_q[FB_FRAME_START]) // see RL14
    else $error("frame start not raised in device role");
  chk_clear_lowers: assert property (sw_clr[FB_IDLE] && !ev_set[FB_IDLE] |=> !flags_q[FB_IDLE]) // see RL16
    else $error("flag kept after write-one clear");
  chk_no_set_disabled: assert property (!enable_q |=> (flags_q & ~$past(flags_q)) == FLAGS_RESET) // see RL6
    else $error("flag raised while disabled");
  chk_read_zero_idle: assert property (!$past(req.rd) |-> rdata == RDATA_RESET) // see RL17
    else $error("read data not zero outside answer cycle");

endmodule

/* File: shared/usb_pwr_pkg.sv */
// Package for the USB power-control and interrupt-flag block.
// Assumes a 50 MHz system clock and a 32-bit register port with word-aligned byte offsets.
package usb_pwr_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_POWER_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_INTERRUPT_FLAGS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ENABLE      = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLEAR       = 8'h0C;

  // Power control bit positions
  localparam int PB_ENABLE  = 0;
  localparam int PB_SUSPEND = 1;
  localparam int PB_BUSY    = 3;
  localparam int PB_GUARD   = 4;
  localparam int PB_PENDING = 7;

  // Interrupt flag bit positions
  localparam int FB_RESET_DETACH = 0;
  localparam int FB_ERROR        = 1;
  localparam int FB_FRAME_START  = 2;
  localparam int FB_TOKEN_DONE   = 3;
  localparam int FB_IDLE         = 4;
  localparam int FB_RESUME       = 5;
  localparam int FB_ATTACH       = 6;
  localparam int FB_STALL        = 7;

  // Widths and reset values
  localparam int          FLAG_W       = 8;
  localparam logic [7:0]  FLAGS_RESET  = 8'h00;
  localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

  // Timing: system clock and documented line times
  localparam int CLK_PERIOD_NS    = 20;
  localparam int K_HOLD_NS        = 2500;
  localparam int QUIET_NS         = 2500;
  localparam int IDLE_MS          = 3;
  localparam int K_HOLD_CYCLES    = (K_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_CYCLES     = (QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYCLES_DOC  = (IDLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHUTDOWN_DEFAULT = 8;

  // Bus line states seen on the data pins
  typedef enum logic [1:0] {LS_SE0, LS_J, LS_K, LS_SE1} line_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Events from the packet engine (same clock)
  typedef struct packed {
    logic stall_rx;
    logic stall_tx;
    logic token_done;
    logic sof_rx;
    logic sof_threshold;
  } pkt_events_t;

endpackage

/* File: tb/usb_far_end.sv */
// Far-end model of the cable partner: drives the two data lines.
// Assumes the bench clock; a requested line state lands one cycle later.
`timescale 1ns/1ns
module usb_far_end
  import usb_pwr_pkg::*;
(
  // Clock
  input  wire logic  clk,
  // Cable presence and requested line state
  input  wire logic  attached,
  input  wire line_t line_req,
  // Data lines towards the block
  output logic       dp_line,
  output logic       dm_line
);
  // Unplugged cable leaves only the pull-downs, so both lines sit at SE0
  always_ff @(posedge clk) begin
    if (!attached) begin
      dp_line <= 1'b0;
      dm_line <= 1'b0;
    end else begin
      dp_line <= (line_req == LS_J) || (line_req == LS_SE1);  // J lifts D+
      dm_line <= (line_req == LS_K) || (line_req == LS_SE1);  // K lifts D-
    end
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the USB power control and interrupt flag block.
// Assumes the far-end model usb_far_end and a 50 MHz clock.
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module testbench import usb_pwr_pkg::*; ;
  localparam logic [31:0] NO_IDLE = 32'hFFFF_FFEF;  // Idle may fire during long J stretches
  logic        clk, resetn, dp_pin, dm_pin, host_role_enable, attached, adv;
  reg_req_t    req;
  logic [31:0] rdata, rd_val;
  pkt_events_t pkt_ev;
  logic [7:0]  err_flags, err_enable, exp_f, msk;
  logic        usb_clk_enable, xcvr_low_power, pins_owned, analog_enable, sleep_block, token_fifo_advance, irq;
  line_t       line_req;
  int          err_count, checks, cycles;
  logic [4:0]  ev;

  usb_power_and_irq_status #(.IDLE_CYCLES(300)) usb_power_and_irq_status_inst (.clk(clk), .resetn(resetn),
    .req(req), .rdata(rdata), .dp_pin(dp_pin), .dm_pin(dm_pin), .pkt_ev(pkt_ev),
    .host_role_enable(host_role_enable), .err_flags(err_flags), .err_enable(err_enable),
    .usb_clk_enable(usb_clk_enable), .xcvr_low_power(xcvr_low_power), .pins_owned(pins_owned),
    .analog_enable(analog_enable), .sleep_block(sleep_block), .token_fifo_advance(token_fifo_advance), .irq(irq));
  usb_far_end usb_far_end_inst (.clk(clk), .attached(attached), .line_req(line_req), .dp_line(dp_pin),
    .dm_line(dm_pin));

  // Expected flag view for a burst of engine events in the given role
  function automatic logic [7:0] exp_flags(input logic host, input logic [4:0] e);
    pkt_events_t p;
    p = e;
    return {(host ? p.stall_rx : p.stall_tx), 3'b000, p.token_done, (host ? p.sof_threshold : p.sof_rx), 2'b00};
  endfunction

  // One-cycle write; advance strobe sampled inside the write cycle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    #1 adv = token_fifo_advance;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  // One-cycle read, then compare the masked word in the answer cycle
  task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 rd_val = rdata & m;
    `CHECK(nm, e, rd_val)
  endtask

  // Engine event burst lasting one cycle
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    pkt_ev <= e;
    @(posedge clk);
    pkt_ev <= '0;
    #1;
  endtask

  // Hold a line state for a number of cycles
  task automatic hold(input line_t s, input int n);
    line_req <= s;
    repeat (n) @(posedge clk);
  endtask

  // Single closing point of the run
  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Free-running bench clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard: the sequence needs about 1400 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32'hED9EAD39));
    {resetn, req, pkt_ev, host_role_enable, err_flags, err_enable, adv} = '0;
    attached = 1'b1;
    line_req = LS_J;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    // Reset state and register map, unmapped and write-only places read zero
    `CHECK("xcvr_low_power", 1'b1, xcvr_low_power)
    foreach (msk[i]) if (i < 5) chk_reg("reset_word", 8'(i * 4), 32'h0, '1);
    wr_reg(OFS_POWER_CONTROL, 32'hFFFF_FFFF);
    chk_reg("power_all_ones", OFS_POWER_CONTROL, 32'h1B, '1);
    `CHECK("clk_gated", 1'b0, usb_clk_enable)
    wr_reg(OFS_POWER_CONTROL, 32'h1);
    `CHECK("outputs_on", 4'b1011, {usb_clk_enable, xcvr_low_power, pins_owned, analog_enable})
    // Line at J since reset: host role sees an attach once the line stays quiet
    host_role_enable <= 1'b1;
    hold(LS_J, 120);
    chk_reg("attach_at_start", OFS_INTERRUPT_FLAGS, 32'h40, 32'h40);
    wr_reg(OFS_INTERRUPT_FLAGS, 32'hFF);
    // Random engine bursts in both roles, random write-one-to-clear masks
    repeat (16) begin
      ev = 5'($urandom);
      host_role_enable <= 1'($urandom);
      wr_reg(OFS_INTERRUPT_FLAGS, 32'hFF);
      pulse(ev);
      exp_f = exp_flags(host_role_enable, ev);
      chk_reg("event_flags", OFS_INTERRUPT_FLAGS, {24'h0, exp_f}, NO_IDLE);
      msk = 8'($urandom);
      wr_reg(OFS_INTERRUPT_FLAGS, {24'hFFFFFF, msk});
      `CHECK("fifo_advance", exp_f[3] & msk[3], adv)
      chk_reg("w1c_flags", OFS_INTERRUPT_FLAGS, {24'h0, exp_f & ~msk}, NO_IDLE);
    end
    // Hardware set wins over a same-cycle clear; writing zero keeps flags
    wr_reg(OFS_INTERRUPT_FLAGS, 32'hFF);
    @(posedge clk);
    req <= '{addr: OFS_INTERRUPT_FLAGS, wdata: 32'h08, wr: 1'b1, rd: 1'b0};
    pkt_ev <= 5'b00100;
    @(posedge clk);
    req.wr <= 1'b0;
    pkt_ev <= '0;
    wr_reg(OFS_INTERRUPT_FLAGS, 32'h0);
    chk_reg("set_beats_clear", OFS_INTERRUPT_FLAGS, 32'h08, NO_IDLE);
    wr_reg(OFS_IRQ_CLEAR, 32'h08);
    chk_reg("clear_reg", OFS_INTERRUPT_FLAGS, 32'h0, NO_IDLE);
    // Error summary follows enabled errors only and ignores writes
    repeat (8) begin
      err_flags <= 8'($urandom);
      err_enable <= 8'($urandom);
      wr_reg(OFS_INTERRUPT_FLAGS, 32'h02);
      chk_reg("error_summary", OFS_INTERRUPT_FLAGS, {30'h0, |(err_flags & err_enable), 1'b0}, NO_IDLE);
    end
    err_flags <= 8'h00;
    // Interrupt output masked, unmasked, then masked again
    host_role_enable <= 1'b0;
    pulse(5'b01000);
    `CHECK("irq_masked", 1'b0, irq)
    wr_reg(OFS_IRQ_ENABLE, 32'hFFFF_FF80);
    `CHECK("irq_on", 1'b1, irq)
    chk_reg("irq_enable_rb", OFS_IRQ_ENABLE, 32'h80, '1);
    wr_reg(OFS_IRQ_ENABLE, 32'h0);
    `CHECK("irq_off", 1'b0, irq)
    // Short K burst: no resume, activity left pending, guard blocks sleep
    hold(LS_K, 60);
    hold(LS_J, 5);
    chk_reg("resume_short", OFS_INTERRUPT_FLAGS, 32'h0, 32'h20);
    chk_reg("pending_set", OFS_POWER_CONTROL, 32'h89, '1);
    wr_reg(OFS_POWER_CONTROL, 32'h11);
    `CHECK("sleep_blocked", 1'b1, sleep_block)
    wr_reg(OFS_POWER_CONTROL, 32'h01);
    `CHECK("sleep_free", 1'b0, sleep_block)
    hold(LS_K, 140);
    chk_reg("resume_long", OFS_INTERRUPT_FLAGS, 32'h20, 32'h20);
    // Raise irq through the stall flag; the resume enable stays off outside suspend
    wr_reg(OFS_IRQ_ENABLE, 32'h80);
    `CHECK("irq_stall", 1'b1, irq)
    chk_reg("pending_clear", OFS_POWER_CONTROL, 32'h09, '1);
    wr_reg(OFS_IRQ_ENABLE, 32'h0);
    wr_reg(OFS_INTERRUPT_FLAGS, 32'hFF);
    // Idle only after the full idle count of J
    hold(LS_J, 200);
    chk_reg("idle_early", OFS_INTERRUPT_FLAGS, 32'h0, 32'h10);
    hold(LS_J, 120);
    chk_reg("idle_set", OFS_INTERRUPT_FLAGS, 32'h10, 32'h10);
    // SE0 means bus reset in device role, detach in host role
    hold(LS_SE0, 140);
    chk_reg("bus_reset", OFS_INTERRUPT_FLAGS, 32'h01, 32'h41);
    host_role_enable <= 1'b1;
    hold(LS_J, 10);
    wr_reg(OFS_INTERRUPT_FLAGS, 32'hFF);
    hold(LS_SE0, 140);
    chk_reg("detach", OFS_INTERRUPT_FLAGS, 32'h01, 32'h41);
    wr_reg(OFS_INTERRUPT_FLAGS, 32'hFF);
    hold(LS_J, 140);
    chk_reg("attach", OFS_INTERRUPT_FLAGS, 32'h40, 32'h41);
    wr_reg(OFS_INTERRUPT_FLAGS, 32'hFF);
    // Disable: busy while shutting down, then ready; software waits it out
    wr_reg(OFS_POWER_CONTROL, 32'h0);
    chk_reg("busy_shutdown", OFS_POWER_CONTROL, 32'h08, '1);
    repeat (12) @(posedge clk);
    chk_reg("busy_done", OFS_POWER_CONTROL, 32'h0, '1);
    pulse(5'b01000);
    chk_reg("off_no_flags", OFS_INTERRUPT_FLAGS, 32'h0, NO_IDLE);
    `CHECK("outputs_off", 4'b0100, {usb_clk_enable, xcvr_low_power, pins_owned, analog_enable})
    print_verdict();
  end
endmodule
